// *** iac_bank.sv ***
// apb register bank for gain, black level, balance, gamma, sharpening, roi
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE_01: gain applied for the selected channel, value in decibel units.
// RULE_02: auto gain off follows manual value; once adjusts then returns off.
// RULE_03: continuous auto gain keeps adjusting; auto maximises dynamic range.
// RULE_04: conversion gain has exactly two settings, low and high.
// RULE_05: black selector offers all, analog, digital; only all is writable.
// RULE_06: integer black offset in native units for the selected entry.
// RULE_07: black offset in percent for the selected entry.
// RULE_08: writable dark current clamp enable; unavailable with rolling shutter.
// RULE_09: one balance ratio per colour, relative to green, chosen by selector.
// RULE_10: auto balance off, once or continuous corrects lighting colour shift.
// RULE_11: gamma value applied, separate bit switches gamma on or off.
// RULE_12: sharpening enable writable, off after reset.
// RULE_13: auto sharpening derives threshold from measured noise level.
// RULE_14: amount scales neighbour difference; negative smooths, positive boosts.
// RULE_15: amount limited to eightfold boost, onefold smoothing; resets to 2.0.
// RULE_16: threshold fraction 0 to 0.25; above 0.25 acts as 0.25.
// RULE_17: while auto sharpening, device threshold replaces the written one.
// RULE_18: sharpening only where gradient exceeds the threshold.
// RULE_19: only pixels inside the region are processed after each image.
// RULE_20: region offsets and sizes counted in pixels from image origin.
// RULE_21: region width limited to full width minus left offset.
// RULE_22: region height limited to full height minus top offset.
// RULE_23: writes to analog and digital black entries are ignored.
module iac_bank
  import iac_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pixel path
  input wire iac_stat_t stat_i,
  input wire logic rolling_shutter_i,
  output iac_cfg_t cfg_o
);

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wr_en = psel_i && penable_i && pwrite_i && pready_o;
  wire rd_en = psel_i && penable_i && !pwrite_i && pready_o;
  wire [15:0] wd = pwdata_i[15:0];
  wire hit_gain = paddr_i == IAC_GAIN_OFF;
  wire hit_gmode = paddr_i == IAC_GMODE_OFF;
  wire hit_conv = paddr_i == IAC_CONV_OFF;
  wire hit_bsel = paddr_i == IAC_BSEL_OFF;
  wire hit_braw = paddr_i == IAC_BRAW_OFF;
  wire hit_bpct = paddr_i == IAC_BPCT_OFF;
  wire hit_clamp = paddr_i == IAC_CLAMP_OFF;
  wire hit_rsel = paddr_i == IAC_RSEL_OFF;
  wire hit_rval = paddr_i == IAC_RVAL_OFF;
  wire hit_wmode = paddr_i == IAC_WMODE_OFF;
  wire hit_gamma = paddr_i == IAC_GAMMA_OFF;
  wire hit_shctl = paddr_i == IAC_SHCTL_OFF;
  wire hit_shamt = paddr_i == IAC_SHAMT_OFF;
  wire hit_shthr = paddr_i == IAC_SHTHR_OFF;
  wire hit_rleft = paddr_i == IAC_RLEFT_OFF;
  wire hit_rwid = paddr_i == IAC_RWID_OFF;
  wire hit_rtop = paddr_i == IAC_RTOP_OFF;
  wire hit_rhgt = paddr_i == IAC_RHGT_OFF;
  wire hit_stat = paddr_i == IAC_STAT_OFF;
  wire mapped = hit_gain | hit_gmode | hit_conv | hit_bsel | hit_braw
    | hit_bpct | hit_clamp | hit_rsel | hit_rval | hit_wmode | hit_gamma
    | hit_shctl | hit_shamt | hit_shthr | hit_rleft | hit_rwid | hit_rtop
    | hit_rhgt | hit_stat;

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] gain_q, braw_q, bpct_q, red_q, blue_q, gamma_q;
  logic [15:0] shamt_q, shthr_q, rleft_q, rwid_q, rtop_q, rhgt_q;
  iac_auto_t gmode_q, wmode_q;
  iac_conv_t conv_q;
  iac_blsel_t bsel_q;
  logic rsel_q, clamp_q, tone_q, shon_q, shauto_q;

  // selector: all, analog and digital can be chosen, code 3 is refused; only all takes offset writes
  // RULE_05 selector entries
  wire bsel_ok = wd[1:0] <= IAC_BL_DIGITAL;
  // RULE_23 read-only entries
  wire bl_writable = bsel_q == IAC_BL_ALL;

  // clamp: amount saturates to +8.0 and -1.0
  // RULE_15 amount limits
  wire signed [15:0] wd_s = $signed(wd);
  wire [15:0] shamt_d = (wd_s > IAC_SHAMT_MAX) ? IAC_SHAMT_MAX :
    (wd_s < IAC_SHAMT_MIN) ? IAC_SHAMT_MIN : wd;
  // RULE_16 threshold ceiling
  wire [15:0] shthr_d = (wd > IAC_SHTHR_MAX) ? IAC_SHTHR_MAX : wd;
  // RULE_21 width limit
  wire [15:0] wid_room = IAC_COLS_MAX - rleft_q;
  wire [15:0] rwid_d = (wd > wid_room) ? wid_room : wd;
  // RULE_22 height limit
  wire [15:0] hgt_room = IAC_ROWS_MAX - rtop_q;
  wire [15:0] rhgt_d = (wd > hgt_room) ? hgt_room : wd;
  wire [15:0] lft_d = (wd > IAC_COLS_MAX) ? IAC_COLS_MAX : wd;
  wire [15:0] top_d = (wd > IAC_ROWS_MAX) ? IAC_ROWS_MAX : wd;

  //////////////////////////////////////////////////////////////////////////
  // automatic gain: steps once per frame toward the peak target
  wire gain_auto = gmode_q != IAC_AUTO_OFF;
  wire peak_high = stat_i.peak_level > IAC_PEAK_TGT;
  wire peak_low = stat_i.peak_level < IAC_PEAK_LOW;
  wire [15:0] gain_up = (gain_q > IAC_GAIN_LIMIT - IAC_GAIN_STEP) ?
    IAC_GAIN_LIMIT : gain_q + IAC_GAIN_STEP;
  wire [15:0] gain_dn = (gain_q < IAC_GAIN_STEP) ? 16'h0000 :
    gain_q - IAC_GAIN_STEP;
  // RULE_03 dynamic range tracking
  wire [15:0] gain_auto_d = peak_high ? gain_dn :
    peak_low ? gain_up : gain_q;

  // automatic balance: ratio = green mean / colour mean in Q8.8
  wire wb_auto = wmode_q != IAC_AUTO_OFF;
  wire [23:0] green_sh = {stat_i.green_mean, 8'h00};
  wire [23:0] red_div = (stat_i.red_mean == 16'h0000) ? 24'h000100 :
    green_sh / {8'h00, stat_i.red_mean};
  wire [23:0] blue_div = (stat_i.blue_mean == 16'h0000) ? 24'h000100 :
    green_sh / {8'h00, stat_i.blue_mean};
  wire [15:0] red_auto = (red_div > 24'h00FFFF) ? 16'hFFFF : red_div[15:0];
  wire [15:0] blue_auto = (blue_div > 24'h00FFFF) ? 16'hFFFF :
    blue_div[15:0];

  // RULE_13 noise derived threshold
  wire [15:0] noise_thr = (stat_i.noise_level > IAC_SHTHR_MAX) ?
    IAC_SHTHR_MAX : stat_i.noise_level;

  //////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gain_q <= IAC_GAIN_RST;
      gmode_q <= IAC_AUTO_OFF;
      conv_q <= IAC_LOW_CONV;
      bsel_q <= IAC_BL_ALL;
      braw_q <= IAC_BRAW_RST;
      bpct_q <= IAC_BPCT_RST;
      clamp_q <= 1'b0;
      rsel_q <= 1'b0;
      red_q <= IAC_RATIO_RST;
      blue_q <= IAC_RATIO_RST;
      wmode_q <= IAC_AUTO_OFF;
      gamma_q <= IAC_GAMMA_RST;
      tone_q <= 1'b0;
      // RULE_12 sharpening off at reset
      shon_q <= 1'b0;
      shauto_q <= 1'b0;
      shamt_q <= IAC_SHAMT_RST;
      shthr_q <= IAC_SHTHR_RST;
      rleft_q <= 16'h0000;
      rwid_q <= IAC_COLS_MAX;
      rtop_q <= 16'h0000;
      rhgt_q <= IAC_ROWS_MAX;
    end else begin
      // RULE_01 manual gain
      if (wr_en && hit_gain && !gain_auto) begin
        gain_q <= wd;
      end else if (gain_auto && stat_i.frame_done) begin
        gain_q <= gain_auto_d;
      end
      // RULE_02 once reverts to off
      if (wr_en && hit_gmode && wd[1:0] <= IAC_AUTO_CONT) begin
        gmode_q <= iac_auto_t'(wd[1:0]);
      end else if (gmode_q == IAC_AUTO_ONCE && stat_i.frame_done) begin
        gmode_q <= IAC_AUTO_OFF;
      end
      // RULE_04 two conversion settings
      if (wr_en && hit_conv) begin
        conv_q <= iac_conv_t'(wd[0]);
      end
      if (wr_en && hit_bsel && bsel_ok) begin
        bsel_q <= iac_blsel_t'(wd[1:0]);
      end
      // RULE_06 raw offset
      if (wr_en && hit_braw && bl_writable) begin
        braw_q <= wd;
      end
      // RULE_07 percent offset
      if (wr_en && hit_bpct && bl_writable) begin
        bpct_q <= wd;
      end
      if (wr_en && hit_clamp) begin
        clamp_q <= wd[0];
      end
      if (wr_en && hit_rsel) begin
        rsel_q <= wd[0];
      end
      // RULE_09 per-colour ratio
      if (wr_en && hit_rval && !wb_auto && !rsel_q) begin
        red_q <= wd;
      end else if (wb_auto && stat_i.frame_done) begin
        red_q <= red_auto;
      end
      if (wr_en && hit_rval && !wb_auto && rsel_q) begin
        blue_q <= wd;
      end else if (wb_auto && stat_i.frame_done) begin
        blue_q <= blue_auto;
      end
      // RULE_10 balance mode, once reverts
      if (wr_en && hit_wmode && wd[1:0] <= IAC_AUTO_CONT) begin
        wmode_q <= iac_auto_t'(wd[1:0]);
      end else if (wmode_q == IAC_AUTO_ONCE && stat_i.frame_done) begin
        wmode_q <= IAC_AUTO_OFF;
      end
      // RULE_11 gamma value and enable
      if (wr_en && hit_gamma) begin
        gamma_q <= wd;
        tone_q <= pwdata_i[IAC_GAMMA_ON_BIT];
      end
      if (wr_en && hit_shctl) begin
        shon_q <= pwdata_i[IAC_SH_ON_BIT];
        shauto_q <= pwdata_i[IAC_SH_AUTO_BIT];
      end
      // RULE_14 signed amount
      if (wr_en && hit_shamt) begin
        shamt_q <= shamt_d;
      end
      // RULE_17 auto replaces written threshold
      if (shauto_q && stat_i.frame_done) begin
        shthr_q <= noise_thr;
      end else if (wr_en && hit_shthr && !shauto_q) begin
        shthr_q <= shthr_d;
      end
      // RULE_20 pixel units
      if (wr_en && hit_rleft) begin
        rleft_q <= lft_d;
        if (rwid_q > IAC_COLS_MAX - lft_d) begin
          rwid_q <= IAC_COLS_MAX - lft_d;
        end
      end else if (wr_en && hit_rwid) begin
        rwid_q <= rwid_d;
      end
      if (wr_en && hit_rtop) begin
        rtop_q <= top_d;
        if (rhgt_q > IAC_ROWS_MAX - top_d) begin
          rhgt_q <= IAC_ROWS_MAX - top_d;
        end
      end else if (wr_en && hit_rhgt) begin
        rhgt_q <= rhgt_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux; selected black entry shows live analog or digital level
  wire [15:0] braw_rd = (bsel_q == IAC_BL_ANALOG) ? stat_i.analog_black :
    (bsel_q == IAC_BL_DIGITAL) ? stat_i.digital_black : braw_q;
  wire [31:0] rd_mux =
    hit_gain ? {16'h0000, gain_q} :
    hit_gmode ? {30'h0, gmode_q} :
    hit_conv ? {31'h0, conv_q} :
    hit_bsel ? {30'h0, bsel_q} :
    hit_braw ? {16'h0000, braw_rd} :
    hit_bpct ? {16'h0000, bpct_q} :
    hit_clamp ? {31'h0, clamp_q} :
    hit_rsel ? {31'h0, rsel_q} :
    hit_rval ? {16'h0000, rsel_q ? blue_q : red_q} :
    hit_wmode ? {30'h0, wmode_q} :
    hit_gamma ? {15'h0, tone_q, gamma_q} :
    hit_shctl ? {30'h0, shauto_q, shon_q} :
    hit_shamt ? {16'h0000, shamt_q} :
    hit_shthr ? {16'h0000, shthr_q} :
    hit_rleft ? {16'h0000, rleft_q} :
    hit_rwid ? {16'h0000, rwid_q} :
    hit_rtop ? {16'h0000, rtop_q} :
    hit_rhgt ? {16'h0000, rhgt_q} :
    hit_stat ? {31'h0, rolling_shutter_i} : 32'h0;

  // no wait state: ready is registered from the setup phase
  logic ready_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ready_q <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      ready_q <= psel_i && !penable_i;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd_mux : prdata_o;
      pslverr_o <= psel_i && !penable_i && !mapped;
    end
  end
  assign pready_o = ready_q;

  //////////////////////////////////////////////////////////////////////////
  // settings out, all registered
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.gain <= gain_q;
      cfg_o.conv <= conv_q;
      cfg_o.black_raw <= braw_q;
      cfg_o.black_pct <= bpct_q;
      // RULE_08 clamp gated off for rolling shutter
      cfg_o.clamp_on <= clamp_q && !rolling_shutter_i;
      cfg_o.ratio_red <= red_q;
      cfg_o.ratio_blue <= blue_q;
      cfg_o.gamma <= gamma_q;
      cfg_o.tone_curve_on <= tone_q;
      cfg_o.edge_boost_on <= shon_q;
      cfg_o.edge_amount <= shamt_q;
      // RULE_18 gradient gate level
      cfg_o.edge_min_gradient <= shthr_q;
      // RULE_19 region to pixel path
      cfg_o.region_left <= rleft_q;
      cfg_o.region_width <= rwid_q;
      cfg_o.region_top <= rtop_q;
      cfg_o.region_height <= rhgt_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking chk_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence once_frame_s;
    gmode_q == IAC_AUTO_ONCE && stat_i.frame_done && !wr_en;
  endsequence
  sequence cont_frame_s;
    gmode_q == IAC_AUTO_CONT && stat_i.frame_done && !wr_en;
  endsequence
  sequence wb_once_s;
    wmode_q == IAC_AUTO_ONCE && stat_i.frame_done && !wr_en;
  endsequence
  sequence bsel_bad_s;
    wr_en && hit_bsel && wd[1:0] == 2'h3;
  endsequence
  gain_once_a: assert property ( // RULE_02
    once_frame_s |=> gmode_q == IAC_AUTO_OFF)
    else $error("once gain mode did not revert");
  gain_cont_a: assert property ( // RULE_03
    cont_frame_s |=> gmode_q == IAC_AUTO_CONT)
    else $error("continuous gain mode stopped");
  wb_once_a: assert property ( // RULE_10
    wb_once_s |=> wmode_q == IAC_AUTO_OFF)
    else $error("once balance mode did not revert");
  bsel_code_a: assert property ( // RULE_05
    bsel_bad_s |=> $stable(bsel_q))
    else $error("illegal black selector code taken");
  sh_amt_a: assert property ( // RULE_15
    $signed(shamt_q) <= IAC_SHAMT_MAX && $signed(shamt_q) >= IAC_SHAMT_MIN)
    else $error("sharpen amount out of range");
  sh_thr_a: assert property ( // RULE_16
    shthr_q <= IAC_SHTHR_MAX)
    else $error("threshold above ceiling");
  bl_ro_a: assert property ( // RULE_23
    wr_en && hit_braw && bsel_q != IAC_BL_ALL |=> $stable(braw_q))
    else $error("read-only black entry changed");
  clamp_rs_a: assert property ( // RULE_08
    rolling_shutter_i |=> !cfg_o.clamp_on)
    else $error("clamp active with rolling shutter");
  clamp_on_a: assert property ( // RULE_08
    clamp_q && !rolling_shutter_i |=> cfg_o.clamp_on)
    else $error("clamp not applied");
  roi_w_a: assert property ( // RULE_21
    {1'b0, rwid_q} + {1'b0, rleft_q} <= {1'b0, IAC_COLS_MAX})
    else $error("region width too large");
  roi_h_a: assert property ( // RULE_22
    {1'b0, rhgt_q} + {1'b0, rtop_q} <= {1'b0, IAC_ROWS_MAX})
    else $error("region height too large");
  thr_auto_a: assert property ( // RULE_17
    shauto_q && stat_i.frame_done |=> shthr_q == $past(noise_thr))
    else $error("auto threshold not taken");
  gain_man_a: assert property ( // RULE_01
    wr_en && hit_gain && !gain_auto |=> gain_q == $past(wd) ##1
    cfg_o.gain == $past(gain_q))
    else $error("manual gain not applied");

endmodule : iac_bank

// *** iac_pkg.sv ***
// package for the image adjustment control register bank
package iac_pkg;
  // register byte offsets
  localparam logic [7:0] IAC_GAIN_OFF = 8'h00;
  localparam logic [7:0] IAC_GMODE_OFF = 8'h04;
  localparam logic [7:0] IAC_CONV_OFF = 8'h08;
  localparam logic [7:0] IAC_BSEL_OFF = 8'h0C;
  localparam logic [7:0] IAC_BRAW_OFF = 8'h10;
  localparam logic [7:0] IAC_BPCT_OFF = 8'h14;
  localparam logic [7:0] IAC_CLAMP_OFF = 8'h18;
  localparam logic [7:0] IAC_RSEL_OFF = 8'h1C;
  localparam logic [7:0] IAC_RVAL_OFF = 8'h20;
  localparam logic [7:0] IAC_WMODE_OFF = 8'h24;
  localparam logic [7:0] IAC_GAMMA_OFF = 8'h28;
  localparam logic [7:0] IAC_SHCTL_OFF = 8'h2C;
  localparam logic [7:0] IAC_SHAMT_OFF = 8'h30;
  localparam logic [7:0] IAC_SHTHR_OFF = 8'h34;
  localparam logic [7:0] IAC_RLEFT_OFF = 8'h38;
  localparam logic [7:0] IAC_RWID_OFF = 8'h3C;
  localparam logic [7:0] IAC_RTOP_OFF = 8'h40;
  localparam logic [7:0] IAC_RHGT_OFF = 8'h44;
  localparam logic [7:0] IAC_STAT_OFF = 8'h48;
  // field positions in control words
  localparam int IAC_GAMMA_ON_BIT = 16;
  localparam int IAC_SH_ON_BIT = 0;
  localparam int IAC_SH_AUTO_BIT = 1;
  localparam int IAC_ROLLING_BIT = 0;
  // reset values; gain in 1/100 dB, gamma and ratios in Q8.8
  localparam logic [15:0] IAC_GAIN_RST = 16'h0000;
  localparam logic [15:0] IAC_GAMMA_RST = 16'h0100;
  localparam logic [15:0] IAC_RATIO_RST = 16'h0100;
  localparam logic [15:0] IAC_BRAW_RST = 16'h0000;
  localparam logic [15:0] IAC_BPCT_RST = 16'h0000;
  // sharpening amount signed Q8.8: limits +8.0 and -1.0, reset 2.0
  localparam logic signed [15:0] IAC_SHAMT_MAX = 16'sh0800;
  localparam logic signed [15:0] IAC_SHAMT_MIN = -16'sh0100;
  localparam logic [15:0] IAC_SHAMT_RST = 16'h0200;
  // threshold: Q0.16 fraction of full range, 0.25 ceiling
  localparam logic [15:0] IAC_SHTHR_MAX = 16'h4000;
  localparam logic [15:0] IAC_SHTHR_RST = 16'h0000;
  // frame geometry
  localparam logic [15:0] IAC_COLS_MAX = 16'h0640;
  localparam logic [15:0] IAC_ROWS_MAX = 16'h04B0;
  // auto gain step per frame, gain limit and peak-level window
  localparam logic [15:0] IAC_GAIN_STEP = 16'h0010;
  localparam logic [15:0] IAC_GAIN_LIMIT = 16'h0BB8;
  localparam logic [15:0] IAC_PEAK_TGT = 16'hE000;
  localparam logic [15:0] IAC_PEAK_LOW = 16'hA000;

  typedef enum logic [1:0] {
    IAC_AUTO_OFF = 2'h0,
    IAC_AUTO_ONCE = 2'h1,
    IAC_AUTO_CONT = 2'h2
  } iac_auto_t;

  typedef enum logic {
    IAC_LOW_CONV = 1'b0,
    IAC_HIGH_CONV = 1'b1
  } iac_conv_t;

  typedef enum logic [1:0] {
    IAC_BL_ALL = 2'h0,
    IAC_BL_ANALOG = 2'h1,
    IAC_BL_DIGITAL = 2'h2
  } iac_blsel_t;

  // settings handed to the sensor and pixel path
  typedef struct packed {
    logic [15:0] gain;
    iac_conv_t conv;
    logic [15:0] black_raw;
    logic [15:0] black_pct;
    logic clamp_on;
    logic [15:0] ratio_red;
    logic [15:0] ratio_blue;
    logic [15:0] gamma;
    logic tone_curve_on;
    logic edge_boost_on;
    logic [15:0] edge_amount;
    logic [15:0] edge_min_gradient;
    logic [15:0] region_left;
    logic [15:0] region_width;
    logic [15:0] region_top;
    logic [15:0] region_height;
  } iac_cfg_t;

  // per-frame statistics from the pixel path
  typedef struct packed {
    logic frame_done;
    logic [15:0] peak_level;
    logic [15:0] noise_level;
    logic [15:0] red_mean;
    logic [15:0] green_mean;
    logic [15:0] blue_mean;
    logic [15:0] analog_black;
    logic [15:0] digital_black;
  } iac_stat_t;
endpackage : iac_pkg

// *** iac_bank_test.sv ***
// self-checking testbench for the image adjustment control bank
`timescale 1ns/1ps

module iac_bank_test;
  import iac_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } iac_row_t;

  logic clk_sys_i;
  logic sys_rst_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  iac_stat_t stat_i;
  logic rolling_shutter_i;
  iac_cfg_t cfg_o;
  int error_cnt;
  int compares;
  logic [31:0] rdata_v;
  logic err_v;
  iac_row_t rows [18];

  iac_bank i_dut (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .stat_i(stat_i),
    .rolling_shutter_i(rolling_shutter_i),
    .cfg_o(cfg_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg

  task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_cfg

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      error_cnt++;
      $display("wrong value %0t no ready answer", $time);
      print_verdict();
    end
    rdata_v = prdata_o;
    err_v = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    chk_reg(rdata_v, exp, "read data");
    chk_reg({31'h0, err_v}, 32'h0000_0000, "slave error");
  endtask : rd_chk

  task automatic settle();
    repeat (2) @(negedge clk_sys_i);
  endtask : settle

  task automatic frame();
    @(posedge clk_sys_i);
    stat_i.frame_done <= 1'b1;
    @(posedge clk_sys_i);
    stat_i.frame_done <= 1'b0;
    settle();
  endtask : frame

  //////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    compares = 0;
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    rolling_shutter_i = 1'b0;
    stat_i = '0;
    // peak well below the window so auto gain must step up
    stat_i.peak_level = 16'h1000;
    stat_i.noise_level = 16'h0300;
    stat_i.analog_black = 16'h0077;
    stat_i.digital_black = 16'h0088;
    stat_i.green_mean = 16'h0200;
    stat_i.red_mean = 16'h0100;
    stat_i.blue_mean = 16'h0400;
    rows = '{
      '{IAC_GAIN_OFF, 32'h0000_04B0, 32'h0000_04B0},
      '{IAC_CONV_OFF, 32'h0000_0000, 32'h0000_0000},
      '{IAC_GMODE_OFF, 32'h0000_0003, 32'h0000_0000},
      '{IAC_BRAW_OFF, 32'h0000_0123, 32'h0000_0123},
      '{IAC_BPCT_OFF, 32'h0000_0032, 32'h0000_0032},
      '{IAC_CLAMP_OFF, 32'h0000_0001, 32'h0000_0001},
      '{IAC_RSEL_OFF, 32'h0000_0001, 32'h0000_0001},
      '{IAC_RVAL_OFF, 32'h0000_0180, 32'h0000_0180},
      '{IAC_RSEL_OFF, 32'h0000_0000, 32'h0000_0000},
      '{IAC_RVAL_OFF, 32'h0000_00C0, 32'h0000_00C0},
      '{IAC_GAMMA_OFF, 32'h0001_0200, 32'h0001_0200},
      '{IAC_SHAMT_OFF, 32'h0000_0900, 32'h0000_0800},
      '{IAC_SHAMT_OFF, 32'h0000_FE00, 32'h0000_FF00},
      '{IAC_SHTHR_OFF, 32'h0000_5000, 32'h0000_4000},
      '{IAC_SHTHR_OFF, 32'h0000_1000, 32'h0000_1000},
      '{IAC_RLEFT_OFF, 32'h0000_0064, 32'h0000_0064},
      '{IAC_RWID_OFF, 32'h0000_0640, 32'h0000_05DC},
      '{IAC_CONV_OFF, 32'h0000_0001, 32'h0000_0001}
    };
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    settle();
    chk_cfg(cfg_o.edge_amount, IAC_SHAMT_RST, "amount");
    chk_cfg({15'h0, cfg_o.edge_boost_on}, 16'h0000, "sharp on");
    chk_cfg(cfg_o.region_height, IAC_ROWS_MAX, "height");
    rd_chk(IAC_SHCTL_OFF, 32'h0000_0000);
    foreach (rows[i]) begin
      wr_row(i);
    end
    wr_reg(IAC_RTOP_OFF, 32'h0000_00C8);
    wr_reg(IAC_RHGT_OFF, 32'h0000_04B0);
    rd_chk(IAC_RHGT_OFF, 32'h0000_03E8);
    wr_reg(IAC_SHCTL_OFF, 32'h0000_0001);
    settle();
    chk_cfg(cfg_o.gain, 16'h04B0, "gain");
    chk_cfg({15'h0, cfg_o.conv}, 16'h0001, "conv");
    chk_cfg(cfg_o.ratio_blue, 16'h0180, "blue");
    chk_cfg(cfg_o.ratio_red, 16'h00C0, "red");
    chk_cfg({15'h0, cfg_o.tone_curve_on}, 16'h0001, "gamma on");
    chk_cfg(cfg_o.edge_amount, 16'hFF00, "amount");
    chk_cfg(cfg_o.edge_min_gradient, 16'h1000, "thr");
    chk_cfg(cfg_o.region_width, 16'h05DC, "width");
    chk_cfg({15'h0, cfg_o.edge_boost_on}, 16'h0001, "sharp on");
    chk_cfg(cfg_o.black_raw, 16'h0123, "raw");
    chk_cfg(cfg_o.black_pct, 16'h0032, "pct");
    chk_cfg(cfg_o.gamma, 16'h0200, "gamma");
    chk_cfg({15'h0, cfg_o.clamp_on}, 16'h0001, "clamp");
    chk_cfg(cfg_o.region_left, 16'h0064, "left");
    chk_cfg(cfg_o.region_top, 16'h00C8, "top");
    chk_cfg(cfg_o.region_height, 16'h03E8, "height");
    // unmapped place: error flagged, reads zero
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk_reg(rdata_v, 32'h0000_0000, "unmapped data");
    chk_reg({31'h0, err_v}, 32'h0000_0001, "unmapped err");
    // read-only black entries show the sensor levels, writes ignored
    wr_reg(IAC_BSEL_OFF, 32'h0000_0001);
    wr_reg(IAC_BRAW_OFF, 32'h0000_0555);
    rd_chk(IAC_BRAW_OFF, 32'h0000_0077);
    wr_reg(IAC_BSEL_OFF, 32'h0000_0002);
    wr_reg(IAC_BSEL_OFF, 32'h0000_0003);
    rd_chk(IAC_BSEL_OFF, 32'h0000_0002);
    rd_chk(IAC_BRAW_OFF, 32'h0000_0088);
    wr_reg(IAC_BSEL_OFF, 32'h0000_0000);
    rd_chk(IAC_BRAW_OFF, 32'h0000_0123);
    // auto gain once, then continuous
    wr_reg(IAC_GMODE_OFF, 32'h0000_0001);
    frame();
    rd_chk(IAC_GMODE_OFF, 32'h0000_0000);
    rd_chk(IAC_GAIN_OFF, {16'h0, 16'h04B0 + IAC_GAIN_STEP});
    wr_reg(IAC_GMODE_OFF, 32'h0000_0002);
    wr_reg(IAC_GAIN_OFF, 32'h0000_0000);
    frame();
    frame();
    rd_chk(IAC_GMODE_OFF, 32'h0000_0002);
    rd_chk(IAC_GAIN_OFF, {16'h0, 16'h04B0 + 16'd3 * IAC_GAIN_STEP});
    wr_reg(IAC_GMODE_OFF, 32'h0000_0000);
    wr_reg(IAC_GAIN_OFF, 32'h0000_0100);
    rd_chk(IAC_GAIN_OFF, 32'h0000_0100);
    // clamping not offered with a rolling shutter
    @(posedge clk_sys_i);
    rolling_shutter_i <= 1'b1;
    settle();
    chk_cfg({15'h0, cfg_o.clamp_on}, 16'h0000, "clamp");
    rd_chk(IAC_STAT_OFF, 32'h0000_0001);
    @(posedge clk_sys_i);
    rolling_shutter_i <= 1'b0;
    // auto sharpening owns the threshold
    wr_reg(IAC_SHCTL_OFF, 32'h0000_0003);
    wr_reg(IAC_SHTHR_OFF, 32'h0000_2000);
    frame();
    rd_chk(IAC_SHTHR_OFF, 32'h0000_0300);
    chk_cfg(cfg_o.edge_min_gradient, 16'h0300, "auto thr");
    // balance modes: once reverts, continuous refuses ratio writes
    wr_reg(IAC_WMODE_OFF, 32'h0000_0002);
    wr_reg(IAC_RVAL_OFF, 32'h0000_0222);
    rd_chk(IAC_RVAL_OFF, 32'h0000_00C0);
    wr_reg(IAC_WMODE_OFF, 32'h0000_0001);
    frame();
    rd_chk(IAC_WMODE_OFF, 32'h0000_0000);
    // green over colour mean: 0x200/0x100 and 0x200/0x400 in Q8.8
    rd_chk(IAC_RVAL_OFF, 32'h0000_0200);
    chk_cfg(cfg_o.ratio_blue, 16'h0080, "auto blue");
    // reset in mid-run brings every setting back
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    settle();
    chk_cfg(cfg_o.gain, IAC_GAIN_RST, "gain reset");
    chk_cfg(cfg_o.region_width, IAC_COLS_MAX, "width reset");
    rd_chk(IAC_SHCTL_OFF, 32'h0000_0000);
    print_verdict();
  end

  task automatic wr_reg(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask : wr_reg

  task automatic wr_row(input int i);
    wr_reg(rows[i].addr, rows[i].wdata);
    rd_chk(rows[i].addr, rows[i].rdata);
  endtask : wr_row
endmodule : iac_bank_test
